/* File: hw/pss_sequencer.v */
// Operating-state sequencer with auto-resume, broadcast acceptance and droop
`timescale 1ns/100ps
`include "pss_defs.vh"
// =====================================================

module pss_sequencer
#(
  parameter TICK_CYCLES = `PSS_TICK_CYCLES
)
(
  // Clock and reset
  input  wire               CLOCK,
  input  wire               RST_N,
  // Decoded register access from the serial link
  input  wire               REG_WR,
  input  wire               REG_RD,
  input  wire [7:0]         REG_UNIT,
  input  wire [15:0]        REG_ADDR,
  input  wire [15:0]        REG_WDATA,
  output reg  [15:0]        REG_RDATA,
  output reg                REG_RVALID,
  // Plant status
  input  wire               INIT_OK,
  input  wire               CAL_OK,
  input  wire               HALT_IN,
  input  wire               LINE_VALID,
  input  wire               LINE_TRIP,
  input  wire               LINK_OK,
  input  wire               FAULT_IN,
  input  wire signed [15:0] VOLT_SETPOINT,
  input  wire signed [15:0] SRC_CURRENT,
  // Power stage control and status
  output reg  [8:0]         STATE,
  output reg                CONTACTOR_CLOSE,
  output reg                PRECHARGE_EN,
  output reg                POWER_ON,
  output reg                FAULT_LATCHED,
  output reg                RETRY_DELAY,
  output reg  signed [15:0] VREG_TARGET
);

  // =====================================================
  // States
  localparam [8:0] S_INIT  = 9'h001;
  localparam [8:0] S_CAL   = 9'h002;
  localparam [8:0] S_DIS   = 9'h004;
  localparam [8:0] S_CWAIT = 9'h008;
  localparam [8:0] S_CHG   = 9'h010;
  localparam [8:0] S_STBY  = 9'h020;
  localparam [8:0] S_ONL   = 9'h040;
  localparam [8:0] S_OFFL  = 9'h080;
  localparam [8:0] S_FLT   = 9'h100;

  reg  [8:0]  state;
  reg  [8:0]  next_state;
  reg  [15:0] node_addr;
  reg  [15:0] op_cmd;
  reg  [15:0] droop_r;
  reg  [15:0] resume_delay;
  reg  [15:0] retry_limit;
  reg  [15:0] retry_window;
  reg  [15:0] dwell_limit;
  reg         cal_done;
  reg         auto_run;
  reg         next_auto_run;
  reg  [15:0] retry_cnt;
  reg  [15:0] win_cnt;
  reg  [15:0] res_cnt;
  reg  [15:0] dwell_cnt;
  reg  [`PSS_TICK_W-1:0] tick_cnt;
  reg         tick;
  reg         retry_go;
  reg         retry_fail;
  reg  [16:0] retry_next;

  // =====================================================
  // Register access
  function addr_hit;
    input [15:0] a;
    begin
      addr_hit = (REG_ADDR == a);
    end
  endfunction

  // Broadcast unit zero is write-only: no node may answer a read on it
  wire wr_ok   = REG_WR && ((REG_UNIT == node_addr[7:0]) || (REG_UNIT == `PSS_BCAST_UNIT));
  wire rd_ok   = REG_RD && (REG_UNIT == node_addr[7:0]) && (REG_UNIT != `PSS_BCAST_UNIT);
  wire cmd_stb = wr_ok && addr_hit(`PSS_A_OPCMD);
  wire fclr    = wr_ok && addr_hit(`PSS_A_FCLR) && (REG_WDATA == `PSS_FCLR_GO);
  wire op_con  = cmd_stb && (REG_WDATA == `PSS_OP_CONNECT);
  wire op_dis  = cmd_stb && (REG_WDATA == `PSS_OP_DISCONNECT);
  wire op_stb  = cmd_stb && (REG_WDATA == `PSS_OP_STANDBY);
  wire op_run  = cmd_stb && (REG_WDATA == `PSS_OP_RUN);

  // A register write this node takes, for its own unit or the broadcast unit
  function wr_hit;
    input [15:0] a;
    begin
      wr_hit = wr_ok && addr_hit(a);
    end
  endfunction

  reg [15:0] rd_val;
  always @*
  begin
    rd_val = 16'h0000;
    if (addr_hit(`PSS_A_NODE))
      rd_val = node_addr;
    else if (addr_hit(`PSS_A_OPCMD))
      rd_val = op_cmd;
    else if (addr_hit(`PSS_A_DROOP))
      rd_val = droop_r;
    else if (addr_hit(`PSS_A_RESUME))
      rd_val = resume_delay;
    else if (addr_hit(`PSS_A_RLIMIT))
      rd_val = retry_limit;
    else if (addr_hit(`PSS_A_RWIN))
      rd_val = retry_window;
    else if (addr_hit(`PSS_A_DWELL))
      rd_val = dwell_limit;
    else if (addr_hit(`PSS_A_STATUS))
      rd_val = {retry_cnt[4:0], FAULT_LATCHED, 1'b0, state};
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      node_addr    <= `PSS_ADDR_RST;
      op_cmd       <= 16'h0000;
      droop_r      <= `PSS_DROOP_RST;
      resume_delay <= `PSS_RESUME_RST;
      retry_limit  <= `PSS_RLIMIT_RST;
      retry_window <= `PSS_RWIN_RST;
      dwell_limit  <= `PSS_DWELL_RST;
      REG_RDATA    <= 16'h0000;
      REG_RVALID   <= 1'b0;
    end
    else
    begin
      if (wr_hit(`PSS_A_NODE))
        node_addr <= REG_WDATA;
      if (cmd_stb)
        op_cmd <= REG_WDATA;
      if (wr_hit(`PSS_A_DROOP))
        droop_r <= REG_WDATA;
      if (wr_hit(`PSS_A_RESUME))
        resume_delay <= REG_WDATA;
      if (wr_hit(`PSS_A_RLIMIT))
        retry_limit <= REG_WDATA;
      if (wr_hit(`PSS_A_RWIN))
        retry_window <= REG_WDATA;
      if (wr_hit(`PSS_A_DWELL))
        dwell_limit <= REG_WDATA;
      REG_RVALID <= rd_ok;
      REG_RDATA  <= rd_ok ? rd_val : 16'h0000;
    end
  end

  // =====================================================
  // One-second time base
  // Timers count whole ticks, so the resume delay and retry window may run up to one tick short, the dwell timeout up to one tick long
  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      tick_cnt <= {`PSS_TICK_W{1'b0}};
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_CYCLES[`PSS_TICK_W-1:0] - 1'b1)
    begin
      tick_cnt <= {`PSS_TICK_W{1'b0}};
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // =====================================================
  // Retry decision: a retry is due once the line recovered and the delay ran out
  always @*
  begin
    retry_go   = (state == S_OFFL) && LINE_VALID && (res_cnt >= resume_delay);
    retry_next = (win_cnt != 16'h0000) ? ({1'b0, retry_cnt} + 17'h00001) : 17'h00001;
    retry_fail = retry_go && (retry_next > {1'b0, retry_limit});
  end

  wire op_state = (state == S_CHG) || (state == S_STBY) || (state == S_ONL) || (state == S_OFFL);
  wire flt_now  = op_state && (FAULT_IN || HALT_IN);
  wire dwell_to = (state == S_OFFL) && (dwell_limit != 16'h0000) && (dwell_cnt > dwell_limit);

  // =====================================================
  // State sequencing
  always @*
  begin
    next_state    = state;
    next_auto_run = auto_run;
    case (state)
      S_INIT:
        if (INIT_OK)
          next_state = S_CAL;
      S_CAL:
        if (CAL_OK)
          next_state = S_DIS;
      S_DIS:
      begin
        next_auto_run = 1'b0;
        // Run and standby codes fall through here unnoticed
        if (op_con && !HALT_IN)
          next_state = LINE_VALID ? S_CHG : S_CWAIT;
      end
      S_CWAIT:
        if (op_dis)
          next_state = S_DIS;
        else if (LINE_VALID)
          next_state = S_CHG;
      S_CHG:
        if (flt_now)
          next_state = S_FLT;
        else if (op_dis)
          next_state = S_DIS;
        else if (LINK_OK)
          next_state = S_STBY;
      S_STBY:
        if (flt_now)
          next_state = S_FLT;
        else if (op_dis)
          next_state = S_DIS;
        else if (op_run || auto_run)
        begin
          next_state    = S_ONL;
          next_auto_run = 1'b0;
        end
      S_ONL:
        if (flt_now)
          next_state = S_FLT;
        else if (LINE_TRIP)
          next_state = (retry_limit == 16'h0000) ? S_FLT : S_OFFL;
        else if (op_dis)
          next_state = S_DIS;
        else if (op_stb)
          next_state = S_STBY;
      S_OFFL:
        if (flt_now || dwell_to || retry_fail)
          next_state = S_FLT;
        else if (op_dis || op_stb)
          next_state = S_DIS;
        else if (retry_go)
        begin
          next_state    = S_CHG;
          next_auto_run = 1'b1;
        end
      S_FLT:
      begin
        next_auto_run = 1'b0;
        // Commands are ignored; only a clean fault reset leaves
        if (fclr && !FAULT_IN && !HALT_IN)
          next_state = cal_done ? S_DIS : S_CAL;
      end
      default:
        next_state = S_INIT;
    endcase
  end

  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state           <= S_INIT;
      auto_run        <= 1'b0;
      cal_done        <= 1'b0;
      STATE           <= S_INIT;
      CONTACTOR_CLOSE <= 1'b0;
      PRECHARGE_EN    <= 1'b0;
      POWER_ON        <= 1'b0;
      FAULT_LATCHED   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      auto_run <= next_auto_run;
      STATE    <= next_state;
      if (state == S_CAL && CAL_OK)
        cal_done <= 1'b1;
      // Outputs follow the next state so a fault drops power in the same edge
      CONTACTOR_CLOSE <= (next_state == S_STBY) || (next_state == S_ONL);
      PRECHARGE_EN    <= (next_state == S_CHG);
      POWER_ON        <= (next_state == S_ONL);
      FAULT_LATCHED   <= (next_state == S_FLT);
    end
  end

  // =====================================================
  // Retry window, resume delay and offline dwell
  always @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      retry_cnt   <= 16'h0000;
      win_cnt     <= 16'h0000;
      res_cnt     <= 16'h0000;
      dwell_cnt   <= 16'h0000;
      RETRY_DELAY <= 1'b0;
    end
    else
    begin
      if (retry_go)
      begin
        win_cnt   <= retry_window;
        retry_cnt <= retry_next[15:0];
      end
      else if (tick && win_cnt != 16'h0000)
      begin
        win_cnt <= win_cnt - 16'h0001;
        if (win_cnt == 16'h0001)
          retry_cnt <= 16'h0000;
      end
      // Resume delay restarts whenever the line drops out again
      if (state != S_OFFL || !LINE_VALID || retry_go)
        res_cnt <= 16'h0000;
      else if (tick && res_cnt != 16'hFFFF)
        res_cnt <= res_cnt + 16'h0001;
      if (state != S_OFFL)
        dwell_cnt <= 16'h0000;
      else if (tick && dwell_cnt != 16'hFFFF)
        dwell_cnt <= dwell_cnt + 16'h0001;
      RETRY_DELAY <= (next_state == S_OFFL) && LINE_VALID && !retry_go;
    end
  end

  // =====================================================
  // Droop: milliohm times tenths of amps over 1000 gives tenths of volts
  wire signed [32:0] droop_prod = $signed({1'b0, droop_r}) * SRC_CURRENT;
  wire signed [32:0] droop_drop = droop_prod / $signed(`PSS_DROOP_DIV);

  always @(posedge CLOCK)
  begin
    if (!RST_N)
      VREG_TARGET <= 16'h0000;
    else
      VREG_TARGET <= VOLT_SETPOINT - droop_drop[15:0];
  end

endmodule // pss_sequencer

/* File: inc/pss_defs.vh */
// Constants of the power stage operating-state sequencer
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// =====================================================
// Timing
`define PSS_CLK_HZ        20000000
`define PSS_TICK_SEC      1
`define PSS_TICK_CYCLES   (`PSS_CLK_HZ * `PSS_TICK_SEC)
`define PSS_TICK_W        25

// =====================================================
// Register addresses on the serial link
`define PSS_A_NODE        16'h9C85
`define PSS_A_FCLR        16'h9CCE
`define PSS_A_OPCMD       16'h9CCF
`define PSS_A_DROOP       16'h9CDC
`define PSS_A_RESUME      16'h9D39
`define PSS_A_RLIMIT      16'h9D3A
`define PSS_A_RWIN        16'h9D3B
`define PSS_A_DWELL       16'h9D3C
`define PSS_A_STATUS      16'h9D40

// =====================================================
// Reset values
`define PSS_ADDR_RST      16'h0001
`define PSS_DROOP_RST     16'h00FA
`define PSS_RESUME_RST    16'h0001
`define PSS_RLIMIT_RST    16'h0002
`define PSS_RWIN_RST      16'h0005
`define PSS_DWELL_RST     16'h0000

// =====================================================
// Operation codes and field values
`define PSS_OP_CONNECT    16'h0001
`define PSS_OP_DISCONNECT 16'h0002
`define PSS_OP_STANDBY    16'h0003
`define PSS_OP_RUN        16'h0004
`define PSS_FCLR_GO       16'h0001
`define PSS_BCAST_UNIT    8'h00
`define PSS_DROOP_DIV     33'h003E8

`endif

/* File: tb/pss_plant_model.sv */
// AC line and DC link model facing the sequencer
`timescale 1ns/100ps
// ==========================================
// Plant
module pss_plant_model #(parameter LINK_DLY = 3) (
  // Clock and control
  input wire  CLOCK,
  input wire  PRECHARGE_EN,
  input wire  line_ok,
  // Line and link status
  output reg  LINE_VALID = 1'b0,
  output reg  LINE_TRIP = 1'b0,
  output reg  LINK_OK = 1'b0
);
  reg [3:0] chg = 4'h0;
  always @(posedge CLOCK)
  begin
    LINE_VALID <= line_ok;
    LINE_TRIP  <= !line_ok;
    // Link only charges while pre-charge is on, so a slow link shows up as a long Charging
    chg        <= PRECHARGE_EN ? chg + 4'h1 : 4'h0;
    LINK_OK    <= PRECHARGE_EN && chg >= LINK_DLY;
  end
endmodule // pss_plant_model

/* File: tb/pss_sequencer_chk.sv */
// Port-level checker for the operating-state sequencer
`timescale 1ns/100ps
`include "pss_defs.vh"
// ==========================================
// Checker
module pss_sequencer_chk (
  // Clock and reset
  input wire       CLOCK,
  input wire       RST_N,
  // Register link
  input wire       REG_WR,
  input wire       REG_RD,
  input wire [7:0] REG_UNIT,
  input wire [15:0] REG_ADDR,
  input wire [15:0] REG_WDATA,
  input wire       REG_RVALID,
  // Plant and stage
  input wire       HALT_IN,
  input wire       LINE_VALID,
  input wire       LINE_TRIP,
  input wire       FAULT_IN,
  input wire [8:0] STATE,
  input wire       CONTACTOR_CLOSE,
  input wire       PRECHARGE_EN,
  input wire       POWER_ON,
  input wire       FAULT_LATCHED,
  input wire       RETRY_DELAY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Broadcast connect, the only unit that is known without reading the node register
  sequence s_conn;
    REG_WR && REG_UNIT == 8'h00 && REG_ADDR == `PSS_A_OPCMD && REG_WDATA == `PSS_OP_CONNECT;
  endsequence
  sequence s_run;
    REG_WR && REG_ADDR == `PSS_A_OPCMD && REG_WDATA == `PSS_OP_RUN;
  endsequence
  chk_conn_valid: assert property (STATE == 9'h004 && !HALT_IN && LINE_VALID ##0 s_conn |=> STATE == 9'h010)
    else $error("connect with valid line did not reach charging");
  chk_conn_wait: assert property (STATE == 9'h004 && !HALT_IN && !LINE_VALID ##0 s_conn |=> STATE == 9'h008)
    else $error("connect without line did not reach charge wait");
  chk_early_run: assert property (STATE[4:0] != 5'h00 ##0 s_run |=> !POWER_ON)
    else $error("run accepted before standby");
  chk_fault_go: assert property ((STATE[5] || STATE[6]) && FAULT_IN |=> STATE == 9'h100 && !CONTACTOR_CLOSE && !POWER_ON)
    else $error("fault did not stop the stage");
  chk_trip_off: assert property (STATE[6] && LINE_TRIP && !FAULT_IN && !HALT_IN && !REG_WR |=> (STATE[7] || STATE[8]) && !CONTACTOR_CLOSE)
    else $error("line trip left the stage running");
  chk_fault_hold: assert property (STATE[8] && !(REG_WR && REG_ADDR == `PSS_A_FCLR) |=> STATE[8])
    else $error("fault state left without fault clear");
  chk_read_ans: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("read answer without a read");
  chk_bcast_read: assert property (REG_RD && REG_UNIT == 8'h00 |=> !REG_RVALID)
    else $error("broadcast read was answered");
  chk_retry_flag: assert property (RETRY_DELAY |-> STATE[7] && !CONTACTOR_CLOSE)
    else $error("retry delay flag outside offline");
  chk_stage_outputs: assert property (CONTACTOR_CLOSE == (STATE[5] || STATE[6]) && POWER_ON == STATE[6])
    else $error("contactor or power output disagrees with state");
  chk_flag_match: assert property (PRECHARGE_EN == STATE[4] && FAULT_LATCHED == STATE[8])
    else $error("pre-charge or fault flag disagrees with state");
endmodule // pss_sequencer_chk

bind pss_sequencer pss_sequencer_chk u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_UNIT(REG_UNIT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RVALID(REG_RVALID), .HALT_IN(HALT_IN),
  .LINE_VALID(LINE_VALID), .LINE_TRIP(LINE_TRIP), .FAULT_IN(FAULT_IN), .STATE(STATE),
  .CONTACTOR_CLOSE(CONTACTOR_CLOSE), .POWER_ON(POWER_ON), .RETRY_DELAY(RETRY_DELAY),
  .PRECHARGE_EN(PRECHARGE_EN), .FAULT_LATCHED(FAULT_LATCHED));

/* File: tb/pss_sequencer_test.sv */
// Testbench for the operating-state sequencer
`timescale 1ns/100ps
`include "pss_defs.vh"
module pss_sequencer_test;
  reg CLOCK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, INIT_OK = 0, CAL_OK = 0, HALT_IN = 0, FAULT_IN = 0, line_ok = 1;
  reg [7:0] REG_UNIT = 0;
  reg [15:0] REG_ADDR = 0, REG_WDATA = 0;
  reg signed [15:0] VOLT_SETPOINT = 16'sd1000, SRC_CURRENT = 16'sd100;
  wire [15:0] REG_RDATA, VREG_TARGET;
  wire [8:0] STATE;
  wire REG_RVALID, LINE_VALID, LINE_TRIP, LINK_OK, CONTACTOR_CLOSE, PRECHARGE_EN, POWER_ON, FAULT_LATCHED, RETRY_DELAY;
  int err_count = 0, cmp_count = 0, i;
  reg [31:0] rows [0:7] = '{{`PSS_A_NODE, `PSS_ADDR_RST}, {`PSS_A_DROOP, 16'h00FA}, {`PSS_A_RESUME, `PSS_RESUME_RST},
    {`PSS_A_RLIMIT, 16'h0002}, {`PSS_A_RWIN, `PSS_RWIN_RST}, {`PSS_A_DWELL, `PSS_DWELL_RST},
    {`PSS_A_FCLR, 16'h0000}, {16'h9C00, 16'h0000}};
  always #25 CLOCK = ~CLOCK;
  pss_sequencer #(.TICK_CYCLES(4)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_UNIT(REG_UNIT), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .INIT_OK(INIT_OK), .CAL_OK(CAL_OK), .HALT_IN(HALT_IN), .LINE_VALID(LINE_VALID), .LINE_TRIP(LINE_TRIP),
    .LINK_OK(LINK_OK), .FAULT_IN(FAULT_IN), .VOLT_SETPOINT(VOLT_SETPOINT), .SRC_CURRENT(SRC_CURRENT),
    .STATE(STATE), .CONTACTOR_CLOSE(CONTACTOR_CLOSE), .PRECHARGE_EN(PRECHARGE_EN), .POWER_ON(POWER_ON),
    .FAULT_LATCHED(FAULT_LATCHED), .RETRY_DELAY(RETRY_DELAY), .VREG_TARGET(VREG_TARGET));
  pss_plant_model plant (.CLOCK(CLOCK), .PRECHARGE_EN(PRECHARGE_EN), .line_ok(line_ok),
    .LINE_VALID(LINE_VALID), .LINE_TRIP(LINE_TRIP), .LINK_OK(LINK_OK));
  // ==========================================
  // Tasks
  task chk(input [15:0] g, input [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] u, input [15:0] a, input [15:0] d);
    @(posedge CLOCK); #5 {REG_WR, REG_UNIT, REG_ADDR, REG_WDATA} = {1'b1, u, a, d};
    @(posedge CLOCK); #5 REG_WR = 0;
  endtask
  // A unit-0 read must stay unanswered
  task rd(input [7:0] u, input [15:0] a, input [15:0] e);
    @(posedge CLOCK); #5 {REG_RD, REG_UNIT, REG_ADDR} = {1'b1, u, a};
    @(posedge CLOCK); #5 REG_RD = 0;
    chk(REG_RVALID, u != 0);
    if (u != 0) chk(REG_RDATA, e);
  endtask
  task wst(input [8:0] s, input int n);
    int k;
    k = 0;
    while (STATE !== s && k < n)
    begin
      @(posedge CLOCK); #5 k++;
    end
    chk(STATE, s);
  endtask
  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial
  begin
    repeat (2) @(posedge CLOCK);
    #5 RST_N = 1;
    chk(STATE, 9'h001);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    chk(STATE, 9'h001);
    chk(VREG_TARGET, 16'd975);
    for (i = 0; i < 8; i++) rd(1, rows[i][31:16], rows[i][15:0]);
    rd(0, `PSS_A_NODE, 0);
    $display("Test reset and registers done");
    INIT_OK = 1;
    wst(9'h002, 3);
    CAL_OK = 1;
    wst(9'h004, 3);
    line_ok = 0;
    HALT_IN = 1;
    wr(0, `PSS_A_OPCMD, `PSS_OP_CONNECT);
    chk(STATE, 9'h004);
    HALT_IN = 0;
    wr(0, `PSS_A_OPCMD, `PSS_OP_CONNECT);
    chk(STATE, 9'h008);
    line_ok = 1;
    wst(9'h010, 4);
    chk(PRECHARGE_EN, 1);
    wst(9'h020, 20);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    chk(POWER_ON, 1);
    wr(1, `PSS_A_OPCMD, `PSS_OP_STANDBY);
    chk(STATE, 9'h020);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    wr(1, `PSS_A_RWIN, 16'h000A);
    $display("Test start-up sequence done");
    // Third retry inside the window must give up
    for (i = 0; i < 3; i++)
    begin
      line_ok = 0;
      wst(9'h080, 5);
      line_ok = 1;
      wst(i < 2 ? 9'h040 : 9'h100, 80);
    end
    rd(1, `PSS_A_STATUS, 16'h1D00);
    wr(1, `PSS_A_FCLR, 16'h0002);
    chk(STATE, 9'h100);
    wr(1, `PSS_A_FCLR, `PSS_FCLR_GO);
    chk(STATE, 9'h004);
    $display("Test auto-resume done");
    wr(0, `PSS_A_RLIMIT, 16'h0000);
    rd(1, `PSS_A_RLIMIT, 16'h0000);
    wr(0, `PSS_A_OPCMD, `PSS_OP_CONNECT);
    wst(9'h020, 20);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    line_ok = 0;
    wst(9'h100, 5);
    line_ok = 1;
    wr(1, `PSS_A_FCLR, `PSS_FCLR_GO);
    wr(0, `PSS_A_OPCMD, `PSS_OP_CONNECT);
    wst(9'h020, 20);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    chk(STATE, 9'h040);
    FAULT_IN = 1;
    wst(9'h100, 3);
    chk(CONTACTOR_CLOSE, 0);
    chk(FAULT_LATCHED, 1);
    $display("Test latch-off and fault done");
    // Window expiry clears the count, a fresh retry counts one, then the offline timeout
    FAULT_IN = 0;
    wr(1, `PSS_A_FCLR, `PSS_FCLR_GO);
    wr(0, `PSS_A_RLIMIT, `PSS_RLIMIT_RST);
    repeat (50) @(posedge CLOCK);
    rd(1, `PSS_A_STATUS, 16'h0004);
    wr(0, `PSS_A_OPCMD, `PSS_OP_CONNECT);
    wst(9'h020, 20);
    wr(0, `PSS_A_OPCMD, `PSS_OP_RUN);
    line_ok = 0;
    wst(9'h080, 5);
    line_ok = 1;
    repeat (2) @(posedge CLOCK);
    #5 chk(RETRY_DELAY, 1);
    wst(9'h040, 80);
    rd(1, `PSS_A_STATUS, 16'h0840);
    repeat (50) @(posedge CLOCK);
    rd(1, `PSS_A_STATUS, 16'h0040);
    wr(0, `PSS_A_DWELL, 16'h0002);
    line_ok = 0;
    wst(9'h080, 5);
    repeat (8) @(posedge CLOCK);
    #5 chk(STATE, 9'h080);
    wst(9'h100, 30);
    chk(FAULT_LATCHED, 1);
    $display("Test retry window and offline timeout done");
    RST_N = 0;
    repeat (2) @(posedge CLOCK);
    #5 RST_N = 1;
    chk(STATE, 9'h001);
    chk(FAULT_LATCHED, 0);
    rd(1, `PSS_A_DWELL, `PSS_DWELL_RST);
    $display("Test mid-run reset done");
    results;
  end
  initial
  begin
    #200000 err_count++;
    $display("Watchdog expired at %0t", $time);
    results;
  end
endmodule // pss_sequencer_test
